/* core/cap_chan.sv */
// one counter array channel: compare and reload storage and pwm output
`timescale 1ns/1ps
`default_nettype none
module cap_chan (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // shared timebase
  input wire logic tick_in,
  input wire logic [15:0] count_in,
  input wire logic [1:0] cycle_len_in,
  input wire logic reload_select_in,
  input wire logic low_wrap_in,
  input wire logic n_wrap_in,
  input wire logic full_wrap_in,
  // mode
  input wire logic pwm_select_in,
  input wire logic pwm16_select_in,
  input wire logic match_flag_enable_in,
  input wire logic watchdog_in,
  // software write port
  input wire logic wr_in,
  input wire logic [1:0] wr_sel_in,
  input wire logic [7:0] wr_data_in,
  // status
  output logic compare_enable_out,
  output logic match_out,
  output logic pin_out,
  output logic [15:0] read_word_out
);
  logic [15:0] compare;
  logic [15:0] reload;
  logic compare_enable;
  logic pin;
  logic [15:0] mask;
  logic hit;
  logic [15:0] next_compare;
  cap_pkg::cap_mode_e mode;

  // ==========================================================
  // mode decode
  always_comb begin
    if (watchdog_in) begin
      mode = cap_pkg::CAP_MODE_TIMER; // RQ16
    end else if (pwm_select_in && pwm16_select_in) begin
      mode = cap_pkg::CAP_MODE_PWM16; // RQ11
    end else if (pwm_select_in) begin
      mode = cap_pkg::CAP_MODE_PWM_N; // RQ3
    end else begin
      mode = cap_pkg::CAP_MODE_OFF;
    end
  end

  // one shared width mask for all narrow pwm channels
  always_comb begin
    unique case (cycle_len_in) // RQ23
      cap_pkg::CLEN_8: mask = 16'h00FF;
      cap_pkg::CLEN_9: mask = 16'h01FF;
      cap_pkg::CLEN_10: mask = 16'h03FF;
      cap_pkg::CLEN_11: mask = 16'h07FF;
    endcase
  end

  always_comb begin
    hit = 1'b0;
    unique case (mode)
      cap_pkg::CAP_MODE_PWM_N: hit = ((count_in + 16'h0001) & mask) == (next_compare & mask); // RQ1 RQ9
      cap_pkg::CAP_MODE_PWM16: hit = (count_in + 16'h0001) == compare; // RQ11
      cap_pkg::CAP_MODE_TIMER: hit = count_in == compare;
      cap_pkg::CAP_MODE_OFF: hit = 1'b0;
    endcase
    hit = hit && tick_in && compare_enable;
  end

  // ==========================================================
  // compare and reload storage
  always_comb begin
    next_compare = compare;
    if (tick_in && mode == cap_pkg::CAP_MODE_PWM_N) begin
      if (cycle_len_in == cap_pkg::CLEN_8 && low_wrap_in) begin
        next_compare = {compare[15:8], compare[15:8]}; // RQ2
      end else if (cycle_len_in != cap_pkg::CLEN_8 && n_wrap_in) begin
        next_compare = reload; // RQ9
      end
    end
    if (wr_in && !reload_select_in) begin // RQ8
      if (wr_sel_in == cap_pkg::SEL_COMP_LOW) begin
        next_compare = {next_compare[15:8], wr_data_in};
      end else begin
        next_compare = {wr_data_in, next_compare[7:0]};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      compare <= cap_pkg::COMPARE_RESET;
    end else begin
      compare <= next_compare;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      reload <= cap_pkg::COMPARE_RESET;
    end else if (wr_in && reload_select_in) begin // RQ8
      if (wr_sel_in == cap_pkg::SEL_COMP_LOW) begin
        reload[7:0] <= wr_data_in;
      end else begin
        reload[15:8] <= wr_data_in;
      end
    end
  end

  // low byte write disarms, high byte write arms
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      compare_enable <= 1'b0;
    end else if (wr_in) begin
      compare_enable <= (wr_sel_in == cap_pkg::SEL_COMP_HIGH); // RQ5
    end
  end

  // ==========================================================
  // output pin: set on match, clear on the width's overflow
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pin <= 1'b0;
    end else if (!compare_enable || mode == cap_pkg::CAP_MODE_OFF
                 || mode == cap_pkg::CAP_MODE_TIMER) begin
      pin <= 1'b0; // RQ7
    end else if (hit) begin
      pin <= 1'b1; // RQ1 RQ6 RQ12
    end else if (tick_in && ((mode == cap_pkg::CAP_MODE_PWM16 && full_wrap_in)
                 || (mode == cap_pkg::CAP_MODE_PWM_N && n_wrap_in))) begin
      pin <= 1'b0; // RQ1 RQ9 RQ11
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      match_out <= 1'b0;
    end else begin
      match_out <= hit && match_flag_enable_in; // RQ10
    end
  end

  assign compare_enable_out = compare_enable;
  assign pin_out = pin;
  assign read_word_out = reload_select_in ? reload : compare; // RQ8
endmodule
`default_nettype wire

/* core/cap_pkg.sv */
// constants shared by the counter array pwm and watchdog block
package cap_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned NUM_CHAN = 3;
  localparam int unsigned WD_CHAN = 2;
  // ==========================================================
  // counter clock selection codes
  localparam logic [2:0] CLK_SEL_DIV12 = 3'h0;
  localparam logic [2:0] CLK_SEL_DIV4 = 3'h1;
  localparam logic [2:0] CLK_SEL_SYS = 3'h4;
  localparam logic [3:0] DIV12_COUNT = 4'hC;
  localparam logic [3:0] DIV4_COUNT = 4'h4;
  // ==========================================================
  // cycle length codes
  localparam logic [1:0] CLEN_8 = 2'h0;
  localparam logic [1:0] CLEN_9 = 2'h1;
  localparam logic [1:0] CLEN_10 = 2'h2;
  localparam logic [1:0] CLEN_11 = 2'h3;
  // ==========================================================
  // reset values
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] WD_OFFSET_RESET = 8'h00;
  localparam logic WD_ENABLE_RESET = 1'b1;
  localparam logic [2:0] CLK_SEL_RESET = 3'h0;
  // ==========================================================
  // register select codes for channel writes
  localparam logic [1:0] SEL_COMP_LOW = 2'h0;
  localparam logic [1:0] SEL_COMP_HIGH = 2'h1;
  // ==========================================================
  // channel modes
  typedef enum logic [1:0] {
    CAP_MODE_OFF,
    CAP_MODE_PWM_N,
    CAP_MODE_PWM16,
    CAP_MODE_TIMER
  } cap_mode_e;
endpackage

/* core/cap_pwm_wd.sv */
// counter array top: shared counter, three pwm channels and channel 2 watchdog
// What this block does
// [RQ1] 8-bit pwm: pin high on low-byte match, low on low-byte overflow.
// [RQ2] 8-bit pwm: low compare byte reloads from high byte on each low wrap.
// [RQ3] 8-bit pwm runs with compare enable, pwm select and cycle length 00.
// [RQ4] pwm overflow flag sets every 256, 512, 1024 or 2048 counter clocks.
// [RQ5] low compare write clears compare enable, high compare write sets it.
// [RQ6] 8-bit high time is 256 minus compare high byte.
// [RQ7] compare enable cleared holds the pin low in every pwm width.
// [RQ8] reload select routes compare byte accesses to the reload register.
// [RQ9] 9-11 bit pwm: match sets pin, bit-N overflow clears, flags, reloads.
// [RQ10] with match flag enable, each comparator match sets the channel flag.
// [RQ11] 16-bit pwm: set on full match, clear on counter overflow.
// [RQ12] 16-bit high time is 65536 minus the compare word.
// [RQ13] software should time 16-bit duty changes to match events.
// [RQ14] watchdog compares channel 2 high byte with counter high byte.
// [RQ15] watchdog on after reset, divide by 12, counter and offset zero.
// [RQ16] watchdog forces counter on, blocks counter writes, freezes selects.
// [RQ17] run bit writes do not stop counter; it reads as software set it.
// [RQ18] any update byte write loads counter high byte plus offset.
// [RQ19] reset when low byte overflows while update byte equals high byte.
// [RQ20] writing 1 to channel 2 flag forces a watchdog reset.
// [RQ21] enable or lock turns watchdog on; lock holds it until reset.
// [RQ22] timeout is 256 times offset plus 256 minus low byte at update.
// [RQ23] all narrow pwm channels share one cycle length setting.
// [RQ24] counter overflow flag sets on 0xFFFF wrap, sticky until cleared.
// [RQ25] watchdog reset leaves as a one-cycle synchronous pulse.
`timescale 1ns/1ps
`default_nettype none
module cap_pwm_wd (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // counter control
  input wire logic counter_run_in,
  input wire logic counter_run_wr_in,
  input wire logic [2:0] counter_clock_sel_in,
  input wire logic idle_suspend_in,
  input wire logic cpu_idle_in,
  input wire logic counter_low_wr_in,
  input wire logic counter_high_wr_in,
  input wire logic [7:0] counter_wr_data_in,
  // watchdog control
  input wire logic watchdog_enable_in,
  input wire logic watchdog_enable_wr_in,
  input wire logic watchdog_lock_set_in,
  // pwm configuration
  input wire logic [1:0] cycle_length_sel_in,
  input wire logic reload_select_in,
  // per channel mode bits
  input wire logic [2:0] pwm_select_in,
  input wire logic [2:0] pwm16_select_in,
  input wire logic [2:0] match_flag_enable_in,
  // channel compare byte writes
  input wire logic [2:0] chan_wr_in,
  input wire logic [1:0] chan_wr_sel_in,
  input wire logic [7:0] chan_wr_data_in,
  // flag writes: a 0 bit clears, a 1 bit on channel 2 forces a watchdog reset
  input wire logic flags_wr_in,
  input wire logic [2:0] chan_event_flag_wr_in,
  input wire logic counter_overflow_flag_clr_in,
  input wire logic pwm_overflow_flag_clr_in,
  // pins and status
  output logic [2:0] chan_output_pin_out,
  output logic [2:0] chan_event_flag_out,
  output logic [2:0] compare_enable_out,
  output logic counter_overflow_flag_out,
  output logic pwm_overflow_flag_out,
  output logic counter_run_out,
  output logic watchdog_active_out,
  output logic watchdog_lock_out,
  output logic [15:0] counter_out,
  output logic [7:0] watchdog_update_byte_out,
  output logic [7:0] watchdog_offset_byte_out,
  output logic watchdog_reset_out
);
  logic [15:0] count;
  logic [3:0] div_count;
  logic [2:0] clock_sel;
  logic idle_sel;
  logic run_bit;
  logic wd_enable;
  logic wd_lock;
  logic wd_active;
  logic tick;
  logic running;
  logic low_wrap;
  logic n_wrap;
  logic full_wrap;
  logic [7:0] wd_update;
  logic [7:0] wd_offset;
  logic [2:0] match;
  logic [2:0] ce;
  logic [2:0] pin;
  logic [15:0] rd_word [3];
  logic [2:0] ch_wr;

  assign wd_active = wd_enable || wd_lock; // RQ21
  assign running = run_bit || wd_active; // RQ16 RQ17
  assign low_wrap = count[7:0] == 8'hFF;
  assign full_wrap = count == 16'hFFFF;

  // ==========================================================
  // counter clock divider
  always_comb begin
    unique case (clock_sel)
      cap_pkg::CLK_SEL_DIV12: tick = div_count == cap_pkg::DIV12_COUNT - 4'h1;
      cap_pkg::CLK_SEL_DIV4: tick = div_count == cap_pkg::DIV4_COUNT - 4'h1;
      default: tick = 1'b1;
    endcase
    tick = tick && running && !(idle_sel && cpu_idle_in);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in || tick) begin
      div_count <= 4'h0;
    end else if (running) begin
      div_count <= div_count + 4'h1;
    end
  end

  // ==========================================================
  // overflow out of bit n for the shared cycle length
  always_comb begin
    unique case (cycle_length_sel_in)
      cap_pkg::CLEN_8: n_wrap = low_wrap;
      cap_pkg::CLEN_9: n_wrap = count[8:0] == 9'h1FF;
      cap_pkg::CLEN_10: n_wrap = count[9:0] == 10'h3FF;
      cap_pkg::CLEN_11: n_wrap = count[10:0] == 11'h7FF;
    endcase
  end

  // ==========================================================
  // configuration bits frozen while the watchdog runs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      clock_sel <= cap_pkg::CLK_SEL_RESET; // RQ15
      idle_sel <= 1'b0;
    end else if (!wd_active) begin
      clock_sel <= counter_clock_sel_in; // RQ16
      idle_sel <= idle_suspend_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      run_bit <= 1'b0;
    end else if (counter_run_wr_in) begin
      run_bit <= counter_run_in; // RQ17
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wd_enable <= cap_pkg::WD_ENABLE_RESET; // RQ15
      wd_lock <= 1'b0;
    end else begin
      if (watchdog_enable_wr_in) begin
        wd_enable <= watchdog_enable_in; // RQ21
      end
      if (watchdog_lock_set_in) begin
        wd_lock <= 1'b1; // RQ21
      end
    end
  end

  // ==========================================================
  // shared counter
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count <= cap_pkg::COUNTER_RESET; // RQ15
    end else if (counter_low_wr_in && !wd_active) begin
      count[7:0] <= counter_wr_data_in; // RQ16
    end else if (counter_high_wr_in && !wd_active) begin
      count[15:8] <= counter_wr_data_in;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // ==========================================================
  // channels; channel 2 compare writes go to the watchdog while it runs
  generate
    for (genvar i = 0; i < cap_pkg::NUM_CHAN; i++) begin : g_chan
      localparam bit IS_WD = (i == cap_pkg::WD_CHAN);
      assign ch_wr[i] = chan_wr_in[i] && !(IS_WD && wd_active);
      cap_chan u_chan (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .count_in(count),
        .cycle_len_in(cycle_length_sel_in),
        .reload_select_in(reload_select_in),
        .low_wrap_in(low_wrap),
        .n_wrap_in(n_wrap),
        .full_wrap_in(full_wrap),
        .pwm_select_in(pwm_select_in[i]),
        .pwm16_select_in(pwm16_select_in[i]),
        .match_flag_enable_in(match_flag_enable_in[i]),
        .watchdog_in(IS_WD && wd_active),
        .wr_in(ch_wr[i]),
        .wr_sel_in(chan_wr_sel_in),
        .wr_data_in(chan_wr_data_in),
        .compare_enable_out(ce[i]),
        .match_out(match[i]),
        .pin_out(pin[i]),
        .read_word_out(rd_word[i])
      );
      always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
          chan_event_flag_out[i] <= 1'b0;
        end else if (match[i]) begin
          chan_event_flag_out[i] <= 1'b1; // RQ10
        end else if (flags_wr_in && !chan_event_flag_wr_in[i]) begin
          chan_event_flag_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // watchdog update and offset bytes
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wd_offset <= cap_pkg::WD_OFFSET_RESET; // RQ15
    end else if (chan_wr_in[cap_pkg::WD_CHAN] && !reload_select_in
                 && chan_wr_sel_in == cap_pkg::SEL_COMP_LOW) begin
      wd_offset <= chan_wr_data_in; // RQ14
    end
  end

  // update byte resets to zero so the first timeout is 256 counter clocks
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wd_update <= cap_pkg::WD_OFFSET_RESET;
    end else if (chan_wr_in[cap_pkg::WD_CHAN] && wd_active
                 && chan_wr_sel_in == cap_pkg::SEL_COMP_HIGH) begin
      wd_update <= count[15:8] + wd_offset; // RQ18 RQ22
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      watchdog_reset_out <= 1'b0;
    end else begin
      watchdog_reset_out <= wd_active && ((tick && low_wrap && wd_update == count[15:8]) // RQ14 RQ19
        || (flags_wr_in && chan_event_flag_wr_in[cap_pkg::WD_CHAN])); // RQ20 RQ25
    end
  end

  // ==========================================================
  // sticky overflow flags, set wins over clear
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      counter_overflow_flag_out <= 1'b0;
    end else if (tick && full_wrap) begin
      counter_overflow_flag_out <= 1'b1; // RQ24
    end else if (counter_overflow_flag_clr_in) begin
      counter_overflow_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pwm_overflow_flag_out <= 1'b0;
    end else if (tick && n_wrap) begin
      pwm_overflow_flag_out <= 1'b1; // RQ4
    end else if (pwm_overflow_flag_clr_in) begin
      pwm_overflow_flag_out <= 1'b0;
    end
  end

  // ==========================================================
  // registered status outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      chan_output_pin_out <= 3'h0;
      compare_enable_out <= 3'h0;
      counter_run_out <= 1'b0;
      watchdog_active_out <= 1'b0;
      watchdog_lock_out <= 1'b0;
      counter_out <= cap_pkg::COUNTER_RESET;
      watchdog_update_byte_out <= 8'h00;
      watchdog_offset_byte_out <= 8'h00;
    end else begin
      chan_output_pin_out <= pin;
      compare_enable_out <= ce;
      counter_run_out <= run_bit; // RQ17
      watchdog_active_out <= wd_active;
      watchdog_lock_out <= wd_lock;
      counter_out <= count;
      watchdog_update_byte_out <= wd_active ? wd_update : rd_word[cap_pkg::WD_CHAN][15:8];
      watchdog_offset_byte_out <= wd_active ? wd_offset : rd_word[cap_pkg::WD_CHAN][7:0];
    end
  end
endmodule
`default_nettype wire

/* testbench/cap_pin_meter.sv */
// load on the channel pins: integrates the high time of each pin
`timescale 1ns/1ps
`default_nettype none
module cap_pin_meter (
  // clock
  input wire logic clk_in,
  // channel pins
  input wire logic [2:0] pin_in,
  // cycles seen high since time zero
  output logic [2:0][31:0] high_cnt_out
);
  // an unknown pin never counts as high, so x shows up as a short count
  initial high_cnt_out = '0;
  always @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (pin_in[i] === 1'b1) begin
        high_cnt_out[i] <= high_cnt_out[i] + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/cap_pwm_wd_checker.sv */
// assertion checker for the counter array pwm and watchdog top
`timescale 1ns/1ps
`default_nettype none
module cap_pwm_wd_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // inputs watched
  input wire logic [2:0] chan_wr_in,
  input wire logic [1:0] chan_wr_sel_in,
  input wire logic flags_wr_in,
  input wire logic [2:0] chan_event_flag_wr_in,
  input wire logic counter_overflow_flag_clr_in,
  input wire logic [2:0] match_flag_enable_in,
  // outputs watched
  input wire logic [2:0] chan_output_pin_out,
  input wire logic [2:0] chan_event_flag_out,
  input wire logic [2:0] compare_enable_out,
  input wire logic counter_overflow_flag_out,
  input wire logic pwm_overflow_flag_out,
  input wire logic watchdog_active_out,
  input wire logic watchdog_lock_out,
  input wire logic [15:0] counter_out,
  input wire logic watchdog_reset_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // ==========================================================
  // channel 0 compare byte writes
  sequence s_low_wr;
    chan_wr_in[0] && chan_wr_sel_in == cap_pkg::SEL_COMP_LOW;
  endsequence
  // a high write not undone by a low write right behind it
  sequence s_high_wr;
    chan_wr_in[0] && chan_wr_sel_in == cap_pkg::SEL_COMP_HIGH ##1 !chan_wr_in[0];
  endsequence
  property p_ce_clear;
    s_low_wr |-> ##2 !compare_enable_out[0];
  endproperty
  a_ce_clear: assert property (p_ce_clear) else $error("low write left enable set");
  property p_ce_set;
    s_high_wr |=> compare_enable_out[0];
  endproperty
  a_ce_set: assert property (p_ce_set) else $error("high write left enable clear");
  // two samples of slack cover the pin register behind the enable
  property p_zero_duty;
    !compare_enable_out[0] && $past(!compare_enable_out[0]) |-> !chan_output_pin_out[0];
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("pin high with enable clear");
  property p_match_flag;
    $rose(chan_output_pin_out[0]) && match_flag_enable_in[0] |-> ##[0:1] chan_event_flag_out[0];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match without flag");
  property p_pwm_wrap;
    $rose(pwm_overflow_flag_out) |-> counter_out[7:0] == 8'hFF;
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm flag off the wrap");
  property p_cf_sticky;
    $fell(counter_overflow_flag_out) |->
      $past(counter_overflow_flag_clr_in) || $past(counter_overflow_flag_clr_in, 2);
  endproperty
  a_cf_sticky: assert property (p_cf_sticky) else $error("overflow flag lost");
  property p_lock_hold;
    watchdog_lock_out |=> watchdog_lock_out && watchdog_active_out;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked watchdog dropped");
  property p_wd_runs;
    watchdog_lock_out |-> ##[1:30] $changed(counter_out);
  endproperty
  a_wd_runs: assert property (p_wd_runs) else $error("counter stalled under watchdog");
  property p_force;
    flags_wr_in && chan_event_flag_wr_in[2] && watchdog_lock_out |-> ##[1:4] watchdog_reset_out;
  endproperty
  a_force: assert property (p_force) else $error("forced reset missing");
  property p_pulse;
    watchdog_reset_out |=> !watchdog_reset_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
endmodule
bind cap_pwm_wd cap_pwm_wd_checker u_chk (.clk_in, .resetn_in, .chan_wr_in, .chan_wr_sel_in,
  .flags_wr_in, .chan_event_flag_wr_in, .counter_overflow_flag_clr_in, .match_flag_enable_in,
  .chan_output_pin_out, .chan_event_flag_out, .compare_enable_out, .counter_overflow_flag_out,
  .pwm_overflow_flag_out, .watchdog_active_out, .watchdog_lock_out, .counter_out,
  .watchdog_reset_out);
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the counter array pwm and watchdog top
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // signals
  logic clk_in = 1'b0, resetn_in = 1'b0;
  logic counter_run_in = 1'b0, counter_run_wr_in = 1'b0;
  logic counter_low_wr_in = 1'b0, counter_high_wr_in = 1'b0;
  logic watchdog_enable_in = 1'b1, watchdog_enable_wr_in = 1'b0, watchdog_lock_set_in = 1'b0;
  logic reload_select_in = 1'b0, flags_wr_in = 1'b0;
  logic counter_overflow_flag_clr_in = 1'b0, pwm_overflow_flag_clr_in = 1'b0;
  logic [1:0] cycle_length_sel_in = 2'h0, chan_wr_sel_in = 2'h0;
  logic [2:0] counter_clock_sel_in = 3'h0, pwm_select_in = 3'h0, pwm16_select_in = 3'h0;
  logic [2:0] match_flag_enable_in = 3'h0, chan_wr_in = 3'h0, chan_event_flag_wr_in = 3'h0;
  logic [7:0] counter_wr_data_in = 8'h00, chan_wr_data_in = 8'h00, d;
  logic [2:0] chan_output_pin_out, chan_event_flag_out, compare_enable_out;
  logic counter_overflow_flag_out, pwm_overflow_flag_out, counter_run_out;
  logic watchdog_active_out, watchdog_lock_out, watchdog_reset_out;
  logic [15:0] counter_out, v;
  logic [7:0] watchdog_update_byte_out, watchdog_offset_byte_out;
  logic [2:0][31:0] high_cnt, hc;
  int num_errors = 0, num_checks = 0, seed, p, n;
  time t0;
  cap_pwm_wd uut (.clk_in, .resetn_in, .counter_run_in, .counter_run_wr_in,
    .counter_clock_sel_in, .idle_suspend_in(1'b0), .cpu_idle_in(1'b0), .counter_low_wr_in,
    .counter_high_wr_in, .counter_wr_data_in, .watchdog_enable_in, .watchdog_enable_wr_in,
    .watchdog_lock_set_in, .cycle_length_sel_in, .reload_select_in, .pwm_select_in,
    .pwm16_select_in, .match_flag_enable_in, .chan_wr_in, .chan_wr_sel_in, .chan_wr_data_in,
    .flags_wr_in, .chan_event_flag_wr_in, .counter_overflow_flag_clr_in,
    .pwm_overflow_flag_clr_in, .chan_output_pin_out, .chan_event_flag_out, .compare_enable_out,
    .counter_overflow_flag_out, .pwm_overflow_flag_out, .counter_run_out, .watchdog_active_out,
    .watchdog_lock_out, .counter_out, .watchdog_update_byte_out, .watchdog_offset_byte_out,
    .watchdog_reset_out);
  cap_pin_meter u_meter (.clk_in, .pin_in(chan_output_pin_out), .high_cnt_out(high_cnt));
  initial forever #25 clk_in = ~clk_in;
  // ==========================================================
  // tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_in);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
  endtask
  task automatic chw(input int ch, input logic [1:0] s, input logic [7:0] b);
    @(negedge clk_in);
    chan_wr_in[ch] = 1'b1;
    chan_wr_sel_in = s;
    chan_wr_data_in = b;
    @(negedge clk_in);
    chan_wr_in = 3'h0;
  endtask
  task automatic wd_en(input logic e);
    watchdog_enable_in = e;
    pulse(watchdog_enable_wr_in);
  endtask
  task automatic meas(input int w);
    logic [2:0][31:0] a;
    a = high_cnt;
    cyc(w);
    for (int i = 0; i < 3; i++) hc[i] = high_cnt[i] - a[i];
  endtask
  task automatic wait_rst(input int lim);
    int k;
    k = 0;
    while (watchdog_reset_out !== 1'b1 && k < lim) begin
      @(negedge clk_in);
      k++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    seed = 2744;
    cyc(4);
    resetn_in = 1'b1;
    t0 = $time;
    // counter write and clock select must be ignored while the watchdog runs
    counter_clock_sel_in = cap_pkg::CLK_SEL_SYS;
    counter_wr_data_in = 8'hF0;
    pulse(counter_low_wr_in);
    counter_run_in = 1'b1;
    pulse(counter_run_wr_in);
    cyc(2);
    chk("run bit", counter_run_out, 1);
    chk("wd on", watchdog_active_out, 1);
    wait_rst(3300);
    n = int'(($time - t0) / 50);
    chk("wd default timeout", n >= 3066 && n <= 3082, 1);
    $display("test watchdog_default done");
    wd_en(1'b0);
    cyc(2);
    chk("wd off", watchdog_active_out, 0);
    cycle_length_sel_in = cap_pkg::CLEN_8;
    pwm_select_in = 3'h3;
    match_flag_enable_in = 3'h1;
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
      chw(0, cap_pkg::SEL_COMP_LOW, d);
      chw(0, cap_pkg::SEL_COMP_HIGH, d);
      cyc(520);
      meas(256);
      chk("pwm8 high", hc[0], 32'd256 - 32'(d));
    end
    chk("match flag", chan_event_flag_out[0], 1);
    match_flag_enable_in = 3'h0;
    pulse(flags_wr_in);
    cyc(2);
    chk("flag cleared", chan_event_flag_out[0], 0);
    chw(0, cap_pkg::SEL_COMP_LOW, 8'h40);
    cyc(3);
    chk("enable cleared", compare_enable_out[0], 0);
    cyc(300);
    meas(256);
    chk("zero duty", hc[0], 0);
    $display("test pwm8 done");
    reload_select_in = 1'b1;
    for (int m = 1; m < 4; m++) begin
      p = 256 << m;
      v = 16'($random(seed)) & 16'(p - 1);
      cycle_length_sel_in = 2'(m);
      chw(0, cap_pkg::SEL_COMP_LOW, v[7:0]);
      chw(0, cap_pkg::SEL_COMP_HIGH, v[15:8]);
      v = 16'(p - 1);
      chw(1, cap_pkg::SEL_COMP_LOW, v[7:0]);
      chw(1, cap_pkg::SEL_COMP_HIGH, v[15:8]);
      v = 16'(p) - high_cnt[0][15:0];
      cyc(2 * p);
      pulse(pwm_overflow_flag_clr_in);
      meas(p);
      chk("enables set", compare_enable_out[1:0], 3);
      chk("pwm_select one clock", hc[1], 1);
      chk("pwm overflow flag", pwm_overflow_flag_out, 1);
      chk("pwm_select in range", hc[0] <= 32'(p), 1);
    end
    reload_select_in = 1'b0;
    $display("test pwm_n done");
    pwm16_select_in = 3'h2;
    match_flag_enable_in = 3'h2;
    counter_wr_data_in = 8'h00;
    pulse(counter_low_wr_in);
    pulse(counter_high_wr_in);
    pulse(counter_overflow_flag_clr_in);
    cyc(2);
    chk("overflow flag clear", counter_overflow_flag_out, 0);
    chw(1, cap_pkg::SEL_COMP_LOW, 8'h00);
    chw(1, cap_pkg::SEL_COMP_HIGH, 8'hFF);
    meas(65536);
    chk("pwm16 high", hc[1], 256);
    chk("overflow flag", counter_overflow_flag_out, 1);
    chk("match flag 16", chan_event_flag_out[1], 1);
    $display("test pwm16 done");
    pwm16_select_in = 3'h0;
    pwm_select_in = 3'h0;
    chw(2, cap_pkg::SEL_COMP_LOW, 8'h02);
    cyc(2);
    chk("offset byte", watchdog_offset_byte_out, 2);
    wd_en(1'b1);
    cyc(2);
    t0 = $time;
    p = 768 - int'(counter_out[7:0]);
    chw(2, cap_pkg::SEL_COMP_HIGH, 8'($random(seed)));
    wait_rst(1000);
    n = int'(($time - t0) / 50);
    chk("wd update timeout", n >= p - 5 && n <= p + 5, 1);
    $display("test watchdog_update done");
    pulse(watchdog_lock_set_in);
    wd_en(1'b0);
    cyc(2);
    chk("lock holds", {watchdog_lock_out, watchdog_active_out}, 3);
    chan_event_flag_wr_in = 3'h7;
    t0 = $time;
    pulse(flags_wr_in);
    wait_rst(8);
    chk("forced reset", ($time - t0) / 50 <= 5, 1);
    $display("test watchdog_lock done");
    finish_test;
  end
  initial begin
    #6000000;
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
